//--- cpt_pkg.sv
// Shared constants and types of the capture port transmitter
package cpt_pkg;

  // Register indices; byte address is four times the index
  localparam logic [17:0] CPT_CFG_IDX = 18'h0E706;
  localparam logic [17:0] CPT_STAT_IDX = 18'h0E7F0;
  localparam logic [19:0] CPT_CFG_ADDR = {CPT_CFG_IDX, 2'b00};
  localparam logic [19:0] CPT_STAT_ADDR = {CPT_STAT_IDX, 2'b00};

  localparam logic [7:0] CPT_CFG_RST = 8'h00;

  // Status register bit positions
  localparam int CPT_ST_BUSY = 0;
  localparam int CPT_ST_OVR = 1;
  localparam int CPT_ST_START = 2;
  localparam int CPT_ST_CNT_LO = 8;

  // Link clock and serial clock rates
  localparam int CPT_LINK_HZ = 32000000;
  localparam int CPT_FAST_HZ = 8000000;
  localparam int CPT_SLOW_HZ = 4000000;
  localparam logic [2:0] CPT_FAST_LAST = 3'(CPT_LINK_HZ / CPT_FAST_HZ - 1);
  localparam logic [2:0] CPT_SLOW_LAST = 3'(CPT_LINK_HZ / CPT_SLOW_HZ - 1);
  localparam logic [2:0] CPT_FAST_HALF = 3'(CPT_LINK_HZ / CPT_FAST_HZ / 2);
  localparam logic [2:0] CPT_SLOW_HALF = 3'(CPT_LINK_HZ / CPT_SLOW_HZ / 2);

  localparam logic [5:0] CPT_WORD_BITS = 6'h20;
  localparam logic [5:0] CPT_BYTE_BITS = 6'h08;
  localparam logic [2:0] CPT_GAP_LAST = 3'h6;

  // Word sets: first memory index and word count
  localparam logic [1:0] CPT_XF_ALL = 2'h0;
  localparam logic [1:0] CPT_XF_SMP = 2'h1;
  localparam logic [1:0] CPT_XF_PWR = 2'h2;
  localparam logic [3:0] CPT_ALL_FIRST = 4'h0;
  localparam logic [4:0] CPT_ALL_CNT = 5'h10;
  localparam logic [3:0] CPT_SMP_FIRST = 4'h0;
  localparam logic [4:0] CPT_SMP_CNT = 5'h07;
  localparam logic [3:0] CPT_PWR_FIRST = 4'h7;
  localparam logic [4:0] CPT_PWR_CNT = 5'h09;

  typedef struct packed {
    logic [1:0] rsvd;
    logic pol;
    logic [1:0] xfer;
    logic gap;
    logic size;
    logic rate;
  } cpt_cfg_t;

  typedef enum logic [3:0] {
    CPT_IDLE = 4'b0001,
    CPT_LOAD = 4'b0010,
    CPT_SHIFT = 4'b0100,
    CPT_GAP = 4'b1000
  } cpt_state_t;

endpackage

//--- cpt_sync.sv
// Two-flop synchroniser for levels and toggles
`timescale 1ns/100ps
module cpt_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

//--- cpt_mem.sv
// Sixteen-word measurement store with registered read
`timescale 1ns/100ps
module cpt_mem (
  input wire logic clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [3:0] waddr,
  input wire logic [31:0] wdata,
  input wire logic re,
  input wire logic [3:0] raddr,
  output logic [31:0] rdata
);

  logic [31:0] mem_r [16];

  always_ff @(posedge clk) begin
    if (we) begin
      mem_r[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 32'h0;
    end else if (re) begin
      rdata <= mem_r[raddr];
    end
  end

endmodule

//--- cpt_top.sv
// Capture port transmitter: APB registers, word store, serial link
//
// Added by the designer: register access over APB.
`timescale 1ns/100ps
module cpt_top
  import cpt_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [19:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sample_we,
  input wire logic [3:0] sample_idx,
  input wire logic [31:0] sample_data,
  input wire logic burst_start,
  output logic capture_serial_clock,
  output logic capture_data,
  output logic frame_active_pin
);

  // ---------------- system clock domain ----------------
  cpt_cfg_t cfg_r;
  cpt_cfg_t bcfg_r;
  logic busy_r;
  logic ovr_r;
  logic start_tgl_r;
  logic ack_tgl_r;
  logic [7:0] burst_cnt_r;
  logic [31:0] hold_r;
  logic rd_pend_r;
  logic done_d_r;
  logic req_d_r;
  logic [1:0] back_s;
  logic done_edge;
  logic req_edge;
  logic [31:0] mem_rdata;
  logic acc_go;
  logic wr_go;
  logic sw_start;
  logic ovr_clr;
  logic start_req;
  logic [31:0] rd_nxt;
  logic err_nxt;

  // ---------------- link clock domain ----------------
  logic lrst_meta_r;
  logic lrst_r;
  logic [2:0] fwd_s;
  logic start_d_r;
  logic ack_d_r;
  logic start_edge;
  logic ack_edge;
  cpt_state_t st_r;
  cpt_cfg_t lcfg_r;
  logic [2:0] ph_r;
  logic [31:0] word_r;
  logic [5:0] wbits_r;
  logic [5:0] pbits_r;
  logic [4:0] wleft_r;
  logic [3:0] idx_r;
  logic [2:0] gap_cnt_r;
  logic req_tgl_r;
  logic done_tgl_r;
  logic [31:0] nxt_word_r;
  logic nxt_vld_r;
  logic sclk_r;
  logic frame_r;
  logic [2:0] bit_last;
  logic [2:0] bit_half;
  logic bit_end;
  logic [5:0] pkg_len;
  logic [3:0] set_first;
  logic [4:0] set_cnt;
  logic take;

  // ---------------- APB slave ----------------
  // One wait state so read data can come from a flop
  assign acc_go = psel & penable & pready;
  assign wr_go = acc_go & pwrite;
  assign sw_start = wr_go & (paddr == CPT_STAT_ADDR) & pwdata[CPT_ST_START];
  assign ovr_clr = wr_go & (paddr == CPT_STAT_ADDR) & pwdata[CPT_ST_OVR];

  always_comb begin
    rd_nxt = 32'h0;
    err_nxt = 1'b1;
    if (paddr == CPT_CFG_ADDR) begin
      rd_nxt = {24'h0, 2'b00, cfg_r[5:0]};
      err_nxt = 1'b0;
    end else if (paddr == CPT_STAT_ADDR) begin
      rd_nxt[CPT_ST_BUSY] = busy_r;
      rd_nxt[CPT_ST_OVR] = ovr_r;
      rd_nxt[CPT_ST_CNT_LO+7:CPT_ST_CNT_LO] = burst_cnt_r;
      err_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready) begin
        prdata <= pwrite ? 32'h0 : rd_nxt;
        pslverr <= err_nxt;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_r <= cpt_cfg_t'(CPT_CFG_RST);
    end else if (wr_go && paddr == CPT_CFG_ADDR) begin
      cfg_r <= cpt_cfg_t'({2'b00, pwdata[5:0]});
    end
  end

  // ---------------- burst launch ----------------
  assign start_req = burst_start | sw_start;

  // Config is frozen per burst so a write mid-burst cannot tear it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
      start_tgl_r <= 1'b0;
      bcfg_r <= cpt_cfg_t'(CPT_CFG_RST);
    end else if (start_req && !busy_r) begin
      busy_r <= 1'b1;
      start_tgl_r <= ~start_tgl_r;
      bcfg_r <= cfg_r;
    end else if (done_edge) begin
      busy_r <= 1'b0;
    end
  end

  // Refused start is flagged; a new refusal beats the clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ovr_r <= 1'b0;
    end else if (start_req && busy_r) begin
      ovr_r <= 1'b1;
    end else if (ovr_clr) begin
      ovr_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      burst_cnt_r <= 8'h00;
    end else if (done_edge) begin
      burst_cnt_r <= burst_cnt_r + 8'h01;
    end
  end

  // ---------------- word server ----------------
  cpt_sync #(
    .W(2)
  ) u_back_sync (
    .clk(clk),
    .rst(rst),
    .d({done_tgl_r, req_tgl_r}),
    .q(back_s)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_d_r <= 1'b0;
      req_d_r <= 1'b0;
    end else begin
      done_d_r <= back_s[1];
      req_d_r <= back_s[0];
    end
  end

  assign done_edge = back_s[1] ^ done_d_r;
  assign req_edge = back_s[0] ^ req_d_r;

  // idx_r is held still from the request toggle until the ack
  cpt_mem u_mem (
    .clk(clk),
    .rst(rst),
    .we(sample_we),
    .waddr(sample_idx),
    .wdata(sample_data),
    .re(req_edge),
    .raddr(idx_r),
    .rdata(mem_rdata)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_pend_r <= 1'b0;
      hold_r <= 32'h0;
      ack_tgl_r <= 1'b0;
    end else begin
      rd_pend_r <= req_edge;
      if (rd_pend_r) begin
        hold_r <= mem_rdata;
        ack_tgl_r <= ~ack_tgl_r;
      end
    end
  end

  // ---------------- link domain ----------------
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      lrst_meta_r <= 1'b1;
      lrst_r <= 1'b1;
    end else begin
      lrst_meta_r <= 1'b0;
      lrst_r <= lrst_meta_r;
    end
  end

  cpt_sync #(
    .W(3)
  ) u_fwd_sync (
    .clk(link_clk),
    .rst(lrst_r),
    .d({start_tgl_r, ack_tgl_r, cfg_r.pol}),
    .q(fwd_s)
  );

  always_ff @(posedge link_clk or posedge lrst_r) begin
    if (lrst_r) begin
      start_d_r <= 1'b0;
      ack_d_r <= 1'b0;
    end else begin
      start_d_r <= fwd_s[2];
      ack_d_r <= fwd_s[1];
    end
  end

  assign start_edge = fwd_s[2] ^ start_d_r;
  assign ack_edge = fwd_s[1] ^ ack_d_r;

  assign bit_last = lcfg_r.rate ? CPT_SLOW_LAST : CPT_FAST_LAST;
  assign bit_half = lcfg_r.rate ? CPT_SLOW_HALF : CPT_FAST_HALF;
  assign bit_end = (ph_r == bit_last);
  assign pkg_len = lcfg_r.size ? CPT_BYTE_BITS : CPT_WORD_BITS;

  always_comb begin
    set_first = CPT_ALL_FIRST;
    set_cnt = CPT_ALL_CNT;
    case (bcfg_r.xfer)
      CPT_XF_SMP: begin
        set_first = CPT_SMP_FIRST;
        set_cnt = CPT_SMP_CNT;
      end
      CPT_XF_PWR: begin
        set_first = CPT_PWR_FIRST;
        set_cnt = CPT_PWR_CNT;
      end
      default: begin
        set_first = CPT_ALL_FIRST;
        set_cnt = CPT_ALL_CNT;
      end
    endcase
  end

  // Next word moves in at a word boundary without a stall
  // word after a gap starts as the gap ends, no extra idle cycle
  assign take = nxt_vld_r && ((st_r == CPT_LOAD) ||
    ((st_r == CPT_SHIFT) && bit_end && wbits_r == 6'h01 &&
     wleft_r != 5'h00 && !lcfg_r.gap) ||
    ((st_r == CPT_GAP) && bit_end && gap_cnt_r == CPT_GAP_LAST &&
     wbits_r == 6'h00));

  always_ff @(posedge link_clk or posedge lrst_r) begin
    if (lrst_r) begin
      nxt_word_r <= 32'h0;
      nxt_vld_r <= 1'b0;
    end else if (ack_edge) begin
      nxt_word_r <= hold_r;
      nxt_vld_r <= 1'b1;
    end else if (take) begin
      nxt_vld_r <= 1'b0;
    end
  end

  always_ff @(posedge link_clk or posedge lrst_r) begin
    if (lrst_r) begin
      st_r <= CPT_IDLE;
      lcfg_r <= cpt_cfg_t'(CPT_CFG_RST);
      ph_r <= 3'h0;
      word_r <= 32'h0;
      wbits_r <= 6'h00;
      pbits_r <= 6'h00;
      wleft_r <= 5'h00;
      idx_r <= 4'h0;
      gap_cnt_r <= 3'h0;
      req_tgl_r <= 1'b0;
      done_tgl_r <= 1'b0;
    end else begin
      case (st_r)
        CPT_IDLE: begin
          if (start_edge) begin
            lcfg_r <= bcfg_r;
            idx_r <= set_first;
            wleft_r <= set_cnt;
            req_tgl_r <= ~req_tgl_r;
            st_r <= CPT_LOAD;
          end
        end
        CPT_LOAD: begin
          ph_r <= 3'h0;
        end
        CPT_SHIFT: begin
          ph_r <= bit_end ? 3'h0 : ph_r + 3'h1;
          if (bit_end) begin
            word_r <= word_r << 1;
            wbits_r <= wbits_r - 6'h01;
            pbits_r <= pbits_r - 6'h01;
            if (wbits_r == 6'h01) begin
              if (wleft_r == 5'h00) begin
                st_r <= CPT_IDLE;
                done_tgl_r <= ~done_tgl_r;
              end else if (lcfg_r.gap) begin
                st_r <= CPT_GAP;
                gap_cnt_r <= 3'h0;
              end else if (!nxt_vld_r) begin
                st_r <= CPT_LOAD;
              end
            end else if (pbits_r == 6'h01) begin
              pbits_r <= pkg_len;
              if (lcfg_r.gap) begin
                st_r <= CPT_GAP;
                gap_cnt_r <= 3'h0;
              end
            end
          end
        end
        CPT_GAP: begin
          ph_r <= bit_end ? 3'h0 : ph_r + 3'h1;
          if (bit_end) begin
            gap_cnt_r <= gap_cnt_r + 3'h1;
            if (gap_cnt_r == CPT_GAP_LAST) begin
              st_r <= (wbits_r == 6'h00) ? CPT_LOAD : CPT_SHIFT;
            end
          end
        end
        default: begin
          st_r <= CPT_IDLE;
        end
      endcase
      if (take) begin
        word_r <= nxt_word_r;
        wbits_r <= CPT_WORD_BITS;
        pbits_r <= pkg_len;
        ph_r <= 3'h0;
        wleft_r <= wleft_r - 5'h01;
        st_r <= CPT_SHIFT;
        if (wleft_r > 5'h01) begin
          idx_r <= idx_r + 4'h1;
          req_tgl_r <= ~req_tgl_r;
        end
      end
    end
  end

  // Clock low in the first half of each bit, idle high otherwise
  always_ff @(posedge link_clk or posedge lrst_r) begin
    if (lrst_r) begin
      sclk_r <= 1'b1;
    end else begin
      sclk_r <= !((st_r == CPT_SHIFT) && (ph_r < bit_half));
    end
  end

  always_ff @(posedge link_clk or posedge lrst_r) begin
    if (lrst_r) begin
      frame_r <= 1'b1;
    end else if (st_r != CPT_IDLE) begin
      frame_r <= lcfg_r.pol;
    end else begin
      frame_r <= ~fwd_s[0];
    end
  end

  assign capture_serial_clock = sclk_r;
  assign capture_data = word_r[31];
  assign frame_active_pin = frame_r;

endmodule

//--- cpt_top_properties.sv
// Port-level assertions of the capture port transmitter
`timescale 1ns/100ps
module cpt_top_properties
  import cpt_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [19:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic capture_serial_clock,
  input wire logic capture_data,
  input wire logic frame_active_pin
);
  logic [5:0] cfg_r;
  logic acc;
  assign acc = psel && penable && pready;
  // Shadow of the config; follows every APB config write, mid-burst too
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_r <= 6'h00;
    end else if (acc && pwrite && paddr == CPT_CFG_ADDR) begin
      cfg_r <= pwdata[5:0];
    end
  end
  chk_ready_pulse: assert property (@(posedge clk) disable iff (rst)
    pready |=> !pready) else $error("pready held too long");
  chk_ready_access: assert property (@(posedge clk) disable iff (rst)
    pready |-> psel && penable) else $error("pready outside access");
  chk_err_map: assert property (@(posedge clk) disable iff (rst)
    pready |-> pslverr == (paddr != CPT_CFG_ADDR && paddr != CPT_STAT_ADDR))
    else $error("pslverr wrong for address");
  chk_cfg_readback: assert property (@(posedge clk) disable iff (rst)
    acc && !pwrite && paddr == CPT_CFG_ADDR |-> prdata == {26'h0, cfg_r})
    else $error("config read back wrong");
  chk_fast_low: assert property (@(posedge link_clk) disable iff (rst)
    $fell(capture_serial_clock) && !cfg_r[0] |=>
    !capture_serial_clock ##1 capture_serial_clock)
    else $error("fast low half wrong");
  chk_slow_low: assert property (@(posedge link_clk) disable iff (rst)
    $fell(capture_serial_clock) && cfg_r[0] |=>
    !capture_serial_clock [*3] ##1 capture_serial_clock)
    else $error("slow low half wrong");
  chk_slow_high: assert property (@(posedge link_clk) disable iff (rst)
    $rose(capture_serial_clock) && cfg_r[0] |=> capture_serial_clock [*3])
    else $error("slow high half short");
  chk_clk_framed: assert property (@(posedge link_clk) disable iff (rst)
    $fell(capture_serial_clock) |-> frame_active_pin == cfg_r[5])
    else $error("serial clock outside frame");
  chk_data_stable: assert property (@(posedge link_clk) disable iff (rst)
    $rose(capture_serial_clock) |-> $stable(capture_data))
    else $error("data moved at rising edge");
  cover property (@(posedge clk) disable iff (rst) pslverr);
  cover property (@(posedge link_clk) disable iff (rst)
    $fell(capture_serial_clock) && cfg_r[2]);
  cover property (@(posedge link_clk) disable iff (rst)
    $fell(capture_serial_clock) && cfg_r[0]);
endmodule

//--- cpt_rx.sv
// Receiver model capturing words from the serial link
`timescale 1ns/100ps
module cpt_rx (
  input wire logic link_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic frame,
  input wire logic pol
);
  logic [31:0] words [16];
  logic [31:0] sh;
  logic prev;
  logic act_q;
  int frames;
  int nw;
  int nb;
  int hi;
  int max_hi;
  wire act = (frame == pol);
  // High runs counted from a rise only, so lead-in idle is ignored
  always @(posedge link_clk or posedge rst) begin
    if (rst) begin
      prev <= 1;
      act_q <= 0;
      frames <= 0;
      nw <= 0;
      nb <= 0;
      hi <= 0;
      max_hi <= 0;
    end else begin
      prev <= sclk;
      act_q <= act;
      if (act && !act_q) begin
        frames <= frames + 1;
        nw <= 0;
        nb <= 0;
        hi <= 0;
        max_hi <= 0;
      end else if (act) begin
        if (!sclk) hi <= 0;
        else if (!prev) hi <= 1;
        else if (hi != 0) hi <= hi + 1;
        if (!sclk && prev && hi > max_hi) max_hi <= hi;
        if (sclk && !prev) begin
          sh <= {sh[30:0], sdata};
          nb <= (nb == 31) ? 0 : nb + 1;
          if (nb == 31 && nw < 16) begin
            words[nw] <= {sh[30:0], sdata};
            nw <= nw + 1;
          end
        end
      end
    end
  end
endmodule

//--- testbench.sv
// Self-checking bench of the capture port transmitter
`timescale 1ns/100ps
module testbench;
  import cpt_pkg::*;
  logic clk = 0;
  logic link_clk = 0;
  logic rst = 1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [19:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic sample_we = 0;
  logic [3:0] sample_idx = '0;
  logic [31:0] sample_data = '0;
  logic burst_start = 0;
  logic pol = 0;
  logic [31:0] prdata, q;
  logic pready, pslverr, sclk, sdata, frame, e;
  logic [7:0] c;
  logic [3:0] first;
  int fails = 0;
  int samples_checked = 0;
  int n, k, j, cnt, f;
  logic [7:0] cfgs [5] = '{8'hC0, 8'h09, 8'h16, 8'h38, 8'h0A};
  always #5 clk = ~clk;
  // Offset keeps link edges off the clk edges
  initial begin
    #2.5;
    forever #15 link_clk = ~link_clk;
  end
  cpt_top cpt_top_i (.clk(clk), .rst(rst), .link_clk(link_clk),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_we(sample_we), .sample_idx(sample_idx),
    .sample_data(sample_data), .burst_start(burst_start),
    .capture_serial_clock(sclk), .capture_data(sdata),
    .frame_active_pin(frame));
  cpt_rx cpt_rx_i (.link_clk(link_clk), .rst(rst), .sclk(sclk),
    .sdata(sdata), .frame(frame), .pol(pol));
  function automatic logic [31:0] exp_w(input int i);
    return 32'h9A5C3E00 ^ (32'(i) * 32'h01111111);
  endfunction
  task end_sim;
    if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task cmp(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task apb(input logic w, input logic [19:0] a, input logic [31:0] d);
    int t;
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    if (t >= 50) begin
      fails++;
      end_sim;
    end
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    for (k = 0; k < 16; k++) begin
      @(posedge clk);
      sample_we <= 1;
      sample_idx <= 4'(k);
      sample_data <= exp_w(k);
    end
    @(posedge clk);
    sample_we <= 0;
    apb(0, CPT_CFG_ADDR, 0);
    cmp(q, 32'h0);
    apb(0, 20'h00100, 0);
    cmp({q[30:0], e}, 32'h1);
    for (k = 0; k < 5; k++) begin
      c = cfgs[k];
      apb(1, CPT_CFG_ADDR, {24'h0, c});
      apb(0, CPT_CFG_ADDR, 0);
      cmp(q, {26'h0, c[5:0]});
      // Let the idle frame level settle first
      repeat (20) @(posedge clk);
      pol <= c[5];
      f = cpt_rx_i.frames;
      first = (c[4:3] == 2'h2) ? 4'h7 : 4'h0;
      cnt = (c[4:3] == 2'h1) ? 7 : (c[4:3] == 2'h2) ? 9 : 16;
      if (k == 4) apb(1, CPT_STAT_ADDR, 32'h4);
      else begin
        burst_start <= 1;
        @(posedge clk);
        // Second start while busy must be refused and flagged
        burst_start <= (k == 1);
        @(posedge clk);
        burst_start <= 0;
      end
      n = 0;
      while (!(cpt_rx_i.frames == f + 1 && cpt_rx_i.nw == cnt &&
          frame == !c[5]) && n < 40000) begin
        @(posedge clk);
        n++;
      end
      if (n >= 40000) begin
        fails++;
        end_sim;
      end
      n = 0;
      do begin
        apb(0, CPT_STAT_ADDR, 0);
        n++;
      end while (q[0] !== 1'b0 && n < 20);
      cmp(q & 32'h1, 32'h0);
      cmp(q & 32'h0000FF03, {16'h0, 8'(k + 1), 6'h0, k == 1, 1'b0});
      if (k == 1) apb(1, CPT_STAT_ADDR, 32'h2);
      cmp(cpt_rx_i.frames, f + 1);
      cmp(cpt_rx_i.max_hi, c[2] ? (c[0] ? 60 : 30) : (c[0] ? 4 : 2));
      for (j = 0; j < cnt; j++)
        cmp(cpt_rx_i.words[j], exp_w(first + j));
      cmp(frame, !c[5]);
    end
    end_sim;
  end
endmodule
bind cpt_top cpt_top_properties cpt_top_properties_i (.clk(clk), .rst(rst),
  .link_clk(link_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .capture_serial_clock(capture_serial_clock),
  .capture_data(capture_data), .frame_active_pin(frame_active_pin));
